/* File: design/pci_host_sig.sv */
// Host-bus side signalling: interrupt, reset, request/grant, power-management event
`timescale 1ns/1ps
`default_nettype none

module pci_host_sig #(
  parameter int unsigned RST_MIN_CYCLES = pci_sig_pkg::RST_MIN_CYC
) (
  // Clock and bus reset
  input  wire logic                          clk_sys,
  input  wire logic                          rstn,
  // Interrupt request pin (open drain)
  output var  logic                          inta_o,
  output var  logic                          inta_oe,
  // Bus request and grant pins
  output var  logic                          req_o,
  output var  logic                          req_oe,
  input  wire logic                          gnt_n_i,
  // Power management event pin (open drain)
  output var  logic                          pme_o,
  output var  logic                          pme_oe,
  // Parity pin for address and write data phases
  output var  logic                          par_o,
  output var  logic                          par_oe,
  // Master data path from the transfer engine
  input  wire logic [31:0]                   ad_out,
  input  wire logic [3:0]                    cbe_out,
  input  wire logic                          ad_drive,
  // Interrupt events and bus need from the controller core
  input  wire logic [pci_sig_pkg::IRQ_W-1:0] irq_flags,
  input  wire logic                          need_bus,
  // Power management sources
  input  wire logic                          pm_event,
  input  wire logic                          magic_packet,
  input  wire logic                          pme_clear,
  input  wire logic [31:0]                   control_status_word_18,
  // Status towards the core
  output var  logic                          bus_owned,
  output var  logic                          init_done,
  output var  logic                          wake_mode
);

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  pci_sig_pkg::sig_state_t state_ff;
  pci_sig_pkg::sig_state_t nxt_state;

  logic wake_on_lan_enable;
  logic wake_style_select;
  logic pme_fire;
  logic reset_long_enough;

  // Control bits taken from the control/status word
  assign wake_on_lan_enable = control_status_word_18[pci_sig_pkg::WAKE_ON_LAN_ENABLE_BIT];
  assign wake_style_select  = control_status_word_18[pci_sig_pkg::WAKE_STYLE_SELECT_BIT];

  // A magic packet only counts once wake mode is actually entered; pm_event always counts
  assign pme_fire = pm_event | (state_ff.wake_mode & magic_packet);

  // The counter saturates, so a long reset never wraps back to short
  assign reset_long_enough = (state_ff.rst_cnt >= RST_MIN_CYCLES[pci_sig_pkg::RST_CNT_W-1:0]);

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;

    // Grant pin comes from the arbiter's domain: two stages before use
    nxt_state.gnt_n_meta = gnt_n_i;
    nxt_state.gnt_n_sync = state_ff.gnt_n_meta;

    // Open-drain pins only ever drive low; release is by enable
    nxt_state.inta.o = pci_sig_pkg::PIN_LOW;
    nxt_state.pme.o  = pci_sig_pkg::PIN_LOW;

    // Interrupt pin follows the OR of the event flags
    nxt_state.inta.oe = |irq_flags;

    // Arbitration: request while the bus is needed, own it once granted
    case (state_ff.arb)
      pci_sig_pkg::ARB_IDLE: begin
        if (need_bus) begin
          nxt_state.arb = pci_sig_pkg::ARB_REQ;
        end
      end
      pci_sig_pkg::ARB_REQ: begin
        if (!need_bus) begin
          nxt_state.arb = pci_sig_pkg::ARB_IDLE;
        end else if (!state_ff.gnt_n_sync) begin
          nxt_state.arb = pci_sig_pkg::ARB_OWN;
        end
      end
      pci_sig_pkg::ARB_OWN: begin
        // Grant withdrawn or work done both end the tenure
        if (!need_bus || state_ff.gnt_n_sync) begin
          nxt_state.arb = need_bus ? pci_sig_pkg::ARB_REQ : pci_sig_pkg::ARB_IDLE;
        end
      end
      default: begin
        nxt_state.arb = pci_sig_pkg::ARB_IDLE;
      end
    endcase

    // Request pin is a driven output, low while requesting or owning
    nxt_state.req.oe = pci_sig_pkg::PIN_HIGH;
    nxt_state.req.o  = (nxt_state.arb == pci_sig_pkg::ARB_IDLE) ? pci_sig_pkg::PIN_HIGH
                                                                : pci_sig_pkg::PIN_LOW;
    nxt_state.bus_owned = (nxt_state.arb == pci_sig_pkg::ARB_OWN);

    // Even parity lags its address/data phase by one edge
    nxt_state.par.o  = ^{ad_out, cbe_out};
    nxt_state.par.oe = ad_drive & state_ff.bus_owned;

    // Wake mode tracks the enable bit
    nxt_state.wake_mode = wake_on_lan_enable;

    // Held style stays low until cleared; pulse style times itself out.
    // A new event in the clearing cycle wins over the clear.
    if (pme_fire) begin
      nxt_state.pme_sticky = 1'b1;
      nxt_state.pme_cnt    = pci_sig_pkg::PME_PULSE_CYC[pci_sig_pkg::PME_CNT_W-1:0];
    end else begin
      if (pme_clear) begin
        nxt_state.pme_sticky = 1'b0;
      end
      if (state_ff.pme_cnt != '0) begin
        nxt_state.pme_cnt = state_ff.pme_cnt - 1'b1;
      end
    end

    if (state_ff.wake_mode && !wake_style_select) begin
      nxt_state.pme.oe = pme_fire | (state_ff.pme_cnt > 1);
    end else begin
      nxt_state.pme.oe = nxt_state.pme_sticky;
    end

    // Initialisation is good only when the preceding reset was long enough
    nxt_state.init_ok = state_ff.init_ok;
    nxt_state.rst_cnt = state_ff.rst_cnt;

    // Bus reset overrides everything: float, release, count its length
    if (!rstn) begin
      nxt_state            = '0;
      nxt_state.arb        = pci_sig_pkg::ARB_IDLE;
      nxt_state.gnt_n_meta = pci_sig_pkg::PIN_HIGH;
      nxt_state.gnt_n_sync = pci_sig_pkg::PIN_HIGH;
      nxt_state.req.o      = pci_sig_pkg::PIN_HIGH;
      nxt_state.req.oe     = pci_sig_pkg::OE_OFF;
      nxt_state.inta.oe    = pci_sig_pkg::OE_OFF;
      nxt_state.pme.oe     = pci_sig_pkg::OE_OFF;
      nxt_state.par.oe     = pci_sig_pkg::OE_OFF;
      nxt_state.rst_cnt    = reset_long_enough ? state_ff.rst_cnt
                                               : state_ff.rst_cnt + 1'b1;
      nxt_state.init_ok    = 1'b0;
    end else begin
      // First cycle after release latches whether reset was long enough;
      // clearing the count every running cycle gives the next reset a clean start
      if (state_ff.rst_cnt != '0) begin
        nxt_state.init_ok = reset_long_enough;
      end
      nxt_state.rst_cnt = '0;
    end
  end

  // ----------------------------------------------------------------------
  // State register, all on the rising clock edge
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    state_ff <= nxt_state;
  end

  // ----------------------------------------------------------------------
  // Outputs, each straight from the state register
  // ----------------------------------------------------------------------
  assign inta_o    = state_ff.inta.o;
  assign inta_oe   = state_ff.inta.oe;
  assign req_o     = state_ff.req.o;
  assign req_oe    = state_ff.req.oe;
  assign pme_o     = state_ff.pme.o;
  assign pme_oe    = state_ff.pme.oe;
  assign par_o     = state_ff.par.o;
  assign par_oe    = state_ff.par.oe;
  assign bus_owned = state_ff.bus_owned;
  assign init_done = state_ff.init_ok;
  assign wake_mode = state_ff.wake_mode;

endmodule

`default_nettype wire

/* File: design/pci_sig_pkg.sv */
// Shared constants and carrier types for the host-bus side signalling block
package pci_sig_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS   = 5000;   // clk_sys at 200 MHz
  localparam int unsigned RST_MIN_US      = 100;    // least bus reset length
  localparam int unsigned RST_MIN_CYC     = (RST_MIN_US * 1000000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
  localparam int unsigned PME_PULSE_NS    = 100;    // pulse-style wake length
  localparam int unsigned PME_PULSE_CYC   = (PME_PULSE_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;

  // ----------------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned IRQ_W           = 8;      // internal interrupt event flags
  localparam int unsigned RST_CNT_W       = 16;
  localparam int unsigned PME_CNT_W       = 6;
  localparam logic        PIN_LOW         = 1'b0;   // level driven while asserted
  localparam logic        PIN_HIGH        = 1'b1;   // driven level of idle request pin
  localparam logic        OE_OFF          = 1'b0;   // reset value of every enable

  // Bit positions inside control_status_word_18
  localparam int unsigned WAKE_ON_LAN_ENABLE_BIT = 18;
  localparam int unsigned WAKE_STYLE_SELECT_BIT  = 17;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_REQ,
    ARB_OWN
  } arb_state_t;

  // One open-drain or driven pin as seen from the device
  typedef struct packed {
    logic o;
    logic oe;
  } pin_drv_t;

  // Whole state of the signalling block
  typedef struct packed {
    logic                   gnt_n_meta;
    logic                   gnt_n_sync;
    arb_state_t             arb;
    pin_drv_t               req;
    pin_drv_t               inta;
    pin_drv_t               pme;
    pin_drv_t               par;
    logic                   pme_sticky;
    logic [PME_CNT_W-1:0]   pme_cnt;
    logic                   wake_mode;
    logic                   bus_owned;
    logic                   init_ok;
    logic [RST_CNT_W-1:0]   rst_cnt;
  } sig_state_t;

endpackage

/* File: tb/pci_arbiter_model.sv */
// Behavioural host arbiter that grants the bus to the device
`timescale 1ns/1ps
`default_nettype none
module pci_arbiter_model (
  // Bus clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // Request from the device, grant back to it
  input  wire logic       req_o,
  input  wire logic       req_oe,
  output var  logic       gnt_n_i,
  // Grant latency in cycles, chosen by the bench
  input  wire logic [3:0] gnt_delay
);
  logic [3:0] wait_cnt;

  initial gnt_n_i = 1'b1;
  // Grant only a driven low request, after the chosen latency
  always @(posedge clk_sys) begin
    if (!rstn || !(req_oe && !req_o)) begin
      wait_cnt <= 4'h0;
      gnt_n_i  <= 1'b1;
    end else if (wait_cnt >= gnt_delay) begin
      gnt_n_i  <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* File: tb/pci_host_sig_sva.sv */
// Assertion checker for the host-bus signalling block
`timescale 1ns/1ps
`default_nettype none
module pci_host_sig_chk #(
  parameter int unsigned RST_MIN_CYCLES = 8
) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  // Bus pins
  input wire logic        inta_o,
  input wire logic        inta_oe,
  input wire logic        req_o,
  input wire logic        req_oe,
  input wire logic        gnt_n_i,
  input wire logic        pme_o,
  input wire logic        pme_oe,
  input wire logic        par_o,
  input wire logic        par_oe,
  // Core side
  input wire logic [31:0] ad_out,
  input wire logic [3:0]  cbe_out,
  input wire logic        ad_drive,
  input wire logic [pci_sig_pkg::IRQ_W-1:0] irq_flags,
  input wire logic        need_bus,
  input wire logic        pm_event,
  input wire logic        magic_packet,
  input wire logic        pme_clear,
  input wire logic [31:0] control_status_word_18,
  input wire logic        bus_owned,
  input wire logic        init_done,
  input wire logic        wake_mode
);
  // One clock domain; reset masks every check but the float one
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_irq_raise: assert property ((|irq_flags) |=> inta_oe)
    else $error("interrupt pin not pulled");
  a_irq_drop: assert property (!(|irq_flags) |=> !inta_oe)
    else $error("interrupt pin pulled without flag");
  a_pins_open_drain: assert property (!inta_o && !pme_o)
    else $error("open drain pin drives high");
  a_reset_float: assert property (disable iff (1'b0) !rstn |=> !(inta_oe | req_oe | pme_oe | par_oe))
    else $error("pin driven during reset");
  a_req_assert: assert property (need_bus |=> !req_o && req_oe)
    else $error("request not asserted");
  a_req_release: assert property (!need_bus |=> req_o)
    else $error("request held without need");
  a_grant_owns: assert property ((need_bus && !gnt_n_i) [*5] |=> bus_owned)
    else $error("grant not taken as ownership");
  a_grant_lost: assert property (gnt_n_i [*4] |=> !bus_owned)
    else $error("ownership without grant");
  a_par_even: assert property (ad_drive && bus_owned |=>
      par_oe && (par_o == (^$past(ad_out) ^ ^$past(cbe_out))))
    else $error("parity wrong or not driven");
  a_wake_enter: assert property (control_status_word_18[18] |=> wake_mode)
    else $error("wake mode not entered");
  a_magic_pme: assert property (wake_mode && magic_packet |=> pme_oe)
    else $error("magic packet gave no event");
  a_pm_event: assert property (pm_event |=> pme_oe)
    else $error("event pin not pulled");
  a_magic_refused: assert property (!wake_mode && magic_packet && !pm_event && !pme_oe
      |=> !pme_oe)
    else $error("magic packet honoured outside wake mode");
endmodule

bind pci_host_sig pci_host_sig_chk #(.RST_MIN_CYCLES(RST_MIN_CYCLES)) chk_inst (.*);
`default_nettype wire

/* File: tb/pci_host_sig_bench.sv */
// Self-checking bench for the host-bus signalling block
`timescale 1ns/1ps
`default_nettype none
module pci_host_sig_bench;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [31:0] ad_out = 32'h0;
  logic [3:0]  cbe_out = 4'h0;
  logic [7:0]  irq_flags = 8'h0;
  logic [31:0] control_status_word_18 = 32'h0;
  logic [3:0]  gnt_delay = 4'h0;
  logic        ad_drive = 1'b0, need_bus = 1'b0, pm_event = 1'b0;
  logic        magic_packet = 1'b0, pme_clear = 1'b0;
  logic        inta_o, inta_oe, req_o, req_oe, gnt_n_i, pme_o, pme_oe;
  logic        par_o, par_oe, bus_owned, init_done, wake_mode;
  int          failures = 0;
  int          checked = 0;

  // Short minimum reset keeps the run brief
  pci_host_sig #(.RST_MIN_CYCLES(4)) pci_host_sig_inst (.clk_sys, .rstn, .inta_o, .inta_oe,
    .req_o, .req_oe, .gnt_n_i, .pme_o, .pme_oe, .par_o, .par_oe, .ad_out, .cbe_out,
    .ad_drive, .irq_flags, .need_bus, .pm_event, .magic_packet, .pme_clear,
    .control_status_word_18, .bus_owned, .init_done, .wake_mode);
  pci_arbiter_model pci_arbiter_model_inst (.clk_sys, .rstn, .req_o, .req_oe, .gnt_n_i,
    .gnt_delay);

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Busy inputs during reset show that reset overrides them
  task automatic do_reset(input int len, input logic exp_init);
    @(posedge clk_sys);
    rstn      <= 1'b0;
    irq_flags <= 8'hFF;
    need_bus  <= 1'b1;
    cyc(len - 1);
    #1 chk("float", 5'h01, {inta_oe, req_oe, pme_oe, par_oe, req_o});
    @(posedge clk_sys);
    rstn      <= 1'b1;
    irq_flags <= 8'h0;
    need_bus  <= 1'b0;
    @(posedge clk_sys);
    #1 chk("init done", exp_init, init_done);
  endtask

  task automatic t_irq();
    @(posedge clk_sys);
    irq_flags <= 8'h80;
    @(posedge clk_sys);
    #1 chk("irq pull", 2'b01, {inta_o, inta_oe});
    @(posedge clk_sys);
    irq_flags <= 8'h0;
    @(posedge clk_sys);
    #1 chk("irq free", 1'b0, inta_oe);
  endtask

  task automatic t_bus(input logic [3:0] d);
    int n;
    @(posedge clk_sys);
    gnt_delay <= d;
    need_bus  <= 1'b1;
    @(posedge clk_sys);
    #1 chk("request", 2'b01, {req_o, req_oe});
    for (n = 0; bus_owned !== 1'b1 && n < 40; n++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("owned", 1'b1, bus_owned);
    @(posedge clk_sys);
    ad_out   <= {d, 28'h0000001};
    cbe_out  <= 4'h7;
    ad_drive <= 1'b1;
    @(posedge clk_sys);
    ad_drive <= 1'b0;
    need_bus <= 1'b0;
    #1 chk("parity", {1'b1, ^{d, 28'h0000001, 4'h7}}, {par_oe, par_o});
    @(posedge clk_sys);
    #1 chk("tenure end", 2'b10, {req_o, bus_owned});
    // Let the withdrawn grant pass the synchroniser before the next request
    cyc(4);
  endtask

  // Pulse style, held style, refused magic packet, plain event
  task automatic t_wake(input logic [31:0] csw, input logic use_pm, input int hold);
    int n;
    @(posedge clk_sys);
    control_status_word_18 <= csw;
    @(posedge clk_sys);
    magic_packet <= !use_pm;
    pm_event     <= use_pm;
    @(posedge clk_sys);
    magic_packet <= 1'b0;
    pm_event     <= 1'b0;
    #1 chk("wake mode", csw[18], wake_mode);
    for (n = 0; pme_oe === 1'b1 && n < 60; n++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("event length", hold, n);
    @(posedge clk_sys);
    pme_clear <= 1'b1;
    @(posedge clk_sys);
    pme_clear <= 1'b0;
    @(posedge clk_sys);
    #1 chk("event cleared", 1'b0, pme_oe);
  endtask

  initial begin
    // Power-up reset leaves the length counter unknown, so judge a second one
    cyc(6);
    rstn <= 1'b1;
    cyc(2);
    do_reset(6, 1'b1);
    t_irq();
    t_bus(4'h0);
    t_bus(4'h7);
    t_wake(32'h0004_0000, 1'b0, pci_sig_pkg::PME_PULSE_CYC);
    t_wake(32'h0006_0000, 1'b0, 60);
    t_wake(32'h0000_0000, 1'b0, 0);
    t_wake(32'h0000_0000, 1'b1, 60);
    do_reset(3, 1'b0);
    print_verdict();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    #20000;
    failures++;
    print_verdict();
  end

  task automatic print_verdict();
    if (failures == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
endmodule
`default_nettype wire
